// file: common/event_select_defines.svh
// Behaviour
// R1: code 0: primary set point, first gains
// R2: code 1 active: secondary set point used
// R3: code 2 active: second gain set used
// R4: code 3 active: both set point and gains
// R5: tuning stores gains into selected set
// R6: code 4: clear alarm 1, retrigger on release
// R7: code 5: clear alarm 2, retrigger on release
// R8: code 6: clear both alarms, retrigger each
// R9: code 7 active: output 1 drive zero
// R10: code 8 active: output 2 drive zero
// R11: code 9 active: both drives zero
// R12: outputs restored as soon as released
// R13: code 10 active: all parameters locked; a finished tuning run still stores its gains into set 1 while locked
// R14: absolute format: secondary used directly
// R15: offset format: primary plus secondary
// R16: swap only in dual-fixed or ramp modes; the code gates only the set point swap, the gain swap works in every mode
// R17: event changing set point aborts tuning
// R18: event synchronised, edges detected once
`ifndef EVENT_SELECT_DEFINES_SVH
`define EVENT_SELECT_DEFINES_SVH

// register byte offsets
`define OFS_CTRL     8'h00
`define OFS_SP_PRI   8'h04
`define OFS_SP_SEC   8'h08
`define OFS_G1_PB    8'h0c
`define OFS_G1_TI    8'h10
`define OFS_G1_TD    8'h14
`define OFS_G2_PB    8'h18
`define OFS_G2_TI    8'h1c
`define OFS_G2_TD    8'h20
`define OFS_TUNE     8'h24
`define OFS_STATUS   8'h28
`define OFS_ACT_SP   8'h2c

// control register fields
`define CTRL_FN_LSB   0
`define CTRL_FN_MSB   3
`define CTRL_FMT_BIT  4
`define CTRL_MODE_LSB 5
`define CTRL_MODE_MSB 7

// tune command bits
`define TUNE_START_BIT 0
`define TUNE_CLR_BIT   1

// reset values
`define RST_SP       16'h0000
`define RST_PB       16'h00b4
`define RST_TI       16'h0064
`define RST_TD       16'h00fa
`define RST_CTRL     8'h00

// ahb constants
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD    3'b010

`endif

// file: common/event_select_pkg.sv
package event_select_pkg;

  typedef logic [15:0] value_t;

  // event input function codes
  typedef enum logic [3:0] {
    fn_none                = 4'h0,
    fn_setpoint_swap       = 4'h1,
    gain_set_swap          = 4'h2,
    setpoint_and_gain_swap = 4'h3,
    clear_alarm_one        = 4'h4,
    clear_alarm_two        = 4'h5,
    clear_both_alarms      = 4'h6,
    kill_output_one        = 4'h7,
    kill_output_two        = 4'h8,
    kill_both_outputs      = 4'h9,
    fn_param_lock          = 4'ha
  } event_fn_e;

  // set point source modes
  typedef enum logic [2:0] {
    single_setpoint_mode     = 3'h0,
    ramp_per_min_mode        = 3'h1,
    ramp_per_hour_mode       = 3'h2,
    remote_in1_mode          = 3'h3,
    remote_in2_mode          = 3'h4,
    dual_fixed_setpoint_mode = 3'h5
  } sp_mode_e;

  typedef struct packed {
    value_t pb;
    value_t ti;
    value_t td;
  } gain_set_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } ahb_req_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } event_edge_s;

endpackage

// file: rtl/event_sync.sv
`timescale 1ns/1ps
`include "event_select_defines.svh"
module event_sync
  import event_select_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  rst_in,
  input  wire logic  pin_in,
  output event_edge_s edge_out
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // two-stage synchroniser; meta_r feeds sync_r only
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // edges are one-cycle pulses, one per transition
  always_comb begin
    edge_out.level = sync_r;
    edge_out.rise  = sync_r & ~last_r;
    edge_out.fall  = ~sync_r & last_r;
  end
endmodule

// file: rtl/event_select.sv
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "event_select_defines.svh"
module event_select
  import event_select_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        event_pin_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire value_t      mv1_in,
  input  wire value_t      mv2_in,
  input  wire logic        alarm1_cond_in,
  input  wire logic        alarm2_cond_in,
  input  wire logic        tune_done_in,
  input  wire gain_set_s   tune_gains_in,
  output value_t           active_setpoint_out,
  output gain_set_s        active_gains_out,
  output value_t           out1_drive_level_out,
  output value_t           out2_drive_level_out,
  output logic             alarm1_out,
  output logic             alarm2_out,
  output logic             param_lock_out,
  output logic             tune_run_out,
  output logic             tune_abort_out,
  output logic             tune_fail_out
);

  event_edge_s ev;
  event_fn_e   event_function_select;
  logic        second_setpoint_format;  // 1 = offset, 0 = absolute
  sp_mode_e    setpoint_source_mode;
  value_t      primary_setpoint;
  value_t      secondary_setpoint;
  gain_set_s   gains_r [2];
  ahb_req_s    req_r;
  logic        rd_wait_r;
  logic        tune_fail_r;
  logic        tune_run_r;

  logic        sp_allowed;
  logic        use_sp2;
  logic        use_g2;
  logic        lock;
  logic        kill1;
  logic        kill2;
  logic        abort;
  logic        wr_en;
  value_t      alt_sp;
  value_t      wdata;
  logic [31:0] rd_nxt;

  // function classification shared by control and checks
  function automatic logic sp_swap_fn(input event_fn_e f);
    return (f == fn_setpoint_swap) || (f == setpoint_and_gain_swap);
  endfunction

  function automatic logic g_swap_fn(input event_fn_e f);
    return (f == gain_set_swap) || (f == setpoint_and_gain_swap);
  endfunction

  function automatic logic clr_a1_fn(input event_fn_e f);
    return (f == clear_alarm_one) || (f == clear_both_alarms);
  endfunction

  function automatic logic clr_a2_fn(input event_fn_e f);
    return (f == clear_alarm_two) || (f == clear_both_alarms);
  endfunction

  // wraps on overflow; software keeps the sum in range
  function automatic value_t sp_add(input value_t a, input value_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0];
  endfunction

  // R18: pin synchronised
  event_sync u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pin_in      (event_pin_in),
    .edge_out    (ev)
  );

  // selection terms from the synchronised event level
  always_comb begin
    // R16: set point swap gated by mode
    sp_allowed = (setpoint_source_mode == dual_fixed_setpoint_mode) ||
                 (setpoint_source_mode == ramp_per_min_mode) ||
                 (setpoint_source_mode == ramp_per_hour_mode);
    // R2: secondary set point
    use_sp2 = ev.level && sp_allowed && sp_swap_fn(event_function_select);
    // R3: second gain set
    use_g2 = ev.level && g_swap_fn(event_function_select);
    // R15: offset format adds
    alt_sp = second_setpoint_format ? sp_add(primary_setpoint, secondary_setpoint)
                                    : secondary_setpoint;
    // R13: parameter lock
    lock  = ev.level && (event_function_select == fn_param_lock);
    kill1 = ev.level && ((event_function_select == kill_output_one) ||
                         (event_function_select == kill_both_outputs));
    kill2 = ev.level && ((event_function_select == kill_output_two) ||
                         (event_function_select == kill_both_outputs));
    // R17: only an edge that really moves the set point
    abort = tune_run_r && (ev.rise || ev.fall) && sp_allowed &&
            sp_swap_fn(event_function_select) && (alt_sp != primary_setpoint);
    // wrong-size writes are dropped rather than half-applied
    wr_en = req_r.valid && req_r.write;
    wdata = hwdata_in[15:0];
  end

  // ahb address phase capture
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      req_r <= '0;
    end else if (hready_in) begin
      req_r.valid <= hsel_in && (htrans_in == `HTRANS_NONSEQ) &&
                     (hsize_in == `HSIZE_WORD || !hwrite_in);
      req_r.write <= hwrite_in;
      req_r.addr  <= haddr_in[7:0];
    end else begin
      req_r.valid <= 1'b0;
    end
  end

  // reads wait one cycle so a write just before is seen
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_wait_r     <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
    end else if (hready_in && hsel_in && htrans_in == `HTRANS_NONSEQ && !hwrite_in) begin
      rd_wait_r     <= 1'b1;
      hreadyout_out <= 1'b0;
    end else if (rd_wait_r) begin
      rd_wait_r     <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out    <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    hresp_out <= 1'b0;  // always okay
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (req_r.addr == `OFS_CTRL) begin
      rd_nxt[`CTRL_FN_MSB:`CTRL_FN_LSB]     = event_function_select;
      rd_nxt[`CTRL_FMT_BIT]                 = second_setpoint_format;
      rd_nxt[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = setpoint_source_mode;
    end else if (req_r.addr == `OFS_SP_PRI) begin
      rd_nxt[15:0] = primary_setpoint;
    end else if (req_r.addr == `OFS_SP_SEC) begin
      rd_nxt[15:0] = secondary_setpoint;
    end else if (req_r.addr == `OFS_G1_PB) begin
      rd_nxt[15:0] = gains_r[0].pb;
    end else if (req_r.addr == `OFS_G1_TI) begin
      rd_nxt[15:0] = gains_r[0].ti;
    end else if (req_r.addr == `OFS_G1_TD) begin
      rd_nxt[15:0] = gains_r[0].td;
    end else if (req_r.addr == `OFS_G2_PB) begin
      rd_nxt[15:0] = gains_r[1].pb;
    end else if (req_r.addr == `OFS_G2_TI) begin
      rd_nxt[15:0] = gains_r[1].ti;
    end else if (req_r.addr == `OFS_G2_TD) begin
      rd_nxt[15:0] = gains_r[1].td;
    end else if (req_r.addr == `OFS_STATUS) begin
      rd_nxt[7:0] = {tune_fail_r, tune_run_r, alarm2_out, alarm1_out,
                     lock, use_g2, use_sp2, ev.level};
    end else if (req_r.addr == `OFS_ACT_SP) begin
      rd_nxt[15:0] = active_setpoint_out;
    end
  end

  // configuration and set points
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      event_function_select  <= fn_none;
      second_setpoint_format <= 1'b0;
      setpoint_source_mode   <= single_setpoint_mode;
      primary_setpoint       <= `RST_SP;
      secondary_setpoint     <= `RST_SP;
    // R13: writes blocked
    end else if (wr_en && !lock) begin
      if (req_r.addr == `OFS_CTRL) begin
        event_function_select  <= event_fn_e'(hwdata_in[`CTRL_FN_MSB:`CTRL_FN_LSB]);
        second_setpoint_format <= hwdata_in[`CTRL_FMT_BIT];
        setpoint_source_mode   <= sp_mode_e'(hwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      end else if (req_r.addr == `OFS_SP_PRI) begin
        primary_setpoint <= wdata;
      end else if (req_r.addr == `OFS_SP_SEC) begin
        secondary_setpoint <= wdata;
      end
    end
  end

  // gain sets; a finished tuning run wins over a bus write
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2; i++) begin
        gains_r[i] <= '{pb: `RST_PB, ti: `RST_TI, td: `RST_TD};
      end
    // R5: tuned values land in selected set
    end else if (tune_done_in && tune_run_r) begin
      gains_r[use_g2] <= tune_gains_in;
    end else if (wr_en && !lock) begin
      if (req_r.addr == `OFS_G1_PB) begin
        gains_r[0].pb <= wdata;
      end else if (req_r.addr == `OFS_G1_TI) begin
        gains_r[0].ti <= wdata;
      end else if (req_r.addr == `OFS_G1_TD) begin
        gains_r[0].td <= wdata;
      end else if (req_r.addr == `OFS_G2_PB) begin
        gains_r[1].pb <= wdata;
      end else if (req_r.addr == `OFS_G2_TI) begin
        gains_r[1].ti <= wdata;
      end else if (req_r.addr == `OFS_G2_TD) begin
        gains_r[1].td <= wdata;
      end
    end
  end

  // tuning run and failure flag; failure set beats clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tune_run_r     <= 1'b0;
      tune_fail_r    <= 1'b0;
      tune_abort_out <= 1'b0;
    end else begin
      tune_abort_out <= abort;
      // R17: abort and flag
      if (abort) begin
        tune_run_r  <= 1'b0;
        tune_fail_r <= 1'b1;
      end else begin
        if (tune_done_in) begin
          tune_run_r <= 1'b0;
        end else if (wr_en && req_r.addr == `OFS_TUNE && hwdata_in[`TUNE_START_BIT]) begin
          tune_run_r <= 1'b1;
        end
        if (wr_en && req_r.addr == `OFS_TUNE && hwdata_in[`TUNE_CLR_BIT]) begin
          tune_fail_r <= 1'b0;
        end
      end
    end
  end

  // control values handed to the loop
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      active_setpoint_out <= `RST_SP;
      active_gains_out    <= '{pb: `RST_PB, ti: `RST_TI, td: `RST_TD};
      param_lock_out      <= 1'b0;
      tune_run_out        <= 1'b0;
      tune_fail_out       <= 1'b0;
    end else begin
      // R1: R4: R14: set point pick
      active_setpoint_out <= use_sp2 ? alt_sp : primary_setpoint;
      // R3: R4: gain set pick
      active_gains_out    <= gains_r[use_g2];
      param_lock_out      <= lock;
      tune_run_out        <= tune_run_r;
      tune_fail_out       <= tune_fail_r;
    end
  end

  // drive levels forced low while killed, restored on release
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      out1_drive_level_out <= 16'h0000;
      out2_drive_level_out <= 16'h0000;
    end else begin
      // R9: R11: R12: output 1
      out1_drive_level_out <= kill1 ? 16'h0000 : mv1_in;
      // R10: R11: R12: output 2
      out2_drive_level_out <= kill2 ? 16'h0000 : mv2_in;
    end
  end

  // latched alarms; held clear while the event stays active
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      alarm1_out <= 1'b0;
      alarm2_out <= 1'b0;
    end else begin
      // R6: R8: alarm 1
      if (ev.level && clr_a1_fn(event_function_select)) begin
        alarm1_out <= 1'b0;
      end else if (alarm1_cond_in) begin
        alarm1_out <= 1'b1;
      end
      // R7: R8: alarm 2
      if (ev.level && clr_a2_fn(event_function_select)) begin
        alarm2_out <= 1'b0;
      end else if (alarm2_cond_in) begin
        alarm2_out <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_none_primary: assert property (  // R1
    event_function_select == fn_none |=> active_setpoint_out == $past(primary_setpoint))
    else $error("set point not primary with no function");
  a_sp_swap: assert property (  // R2
    use_sp2 && !second_setpoint_format |=> active_setpoint_out == $past(secondary_setpoint))
    else $error("secondary set point not applied");
  a_gain_swap: assert property (  // R3
    use_g2 && !(tune_done_in && tune_run_r) |=> active_gains_out == $past(gains_r[1]))
    else $error("second gain set not applied");
  a_both_swap: assert property (  // R4
    ev.level && sp_allowed && event_function_select == setpoint_and_gain_swap
    |=> active_setpoint_out == $past(alt_sp) && active_gains_out == $past(gains_r[1]))
    else $error("set point and gains not swapped together");
  a_tune_store: assert property (  // R5
    tune_done_in && tune_run_r && use_g2 |=> gains_r[1] == $past(tune_gains_in))
    else $error("tuned gains not stored in second set");
  a_alarm_clear: assert property (  // R6
    ev.rise && clr_a1_fn(event_function_select) |=> !alarm1_out)
    else $error("alarm 1 not cleared on activation");
  a_alarm_retrig: assert property (  // R7
    ev.fall && alarm2_cond_in |=> alarm2_out)
    else $error("alarm 2 not retriggered on release");
  a_both_clear: assert property (  // R8
    ev.level && event_function_select == clear_both_alarms |=> !alarm1_out && !alarm2_out)
    else $error("alarms not held clear");
  a_kill_one: assert property (  // R9
    kill1 |=> out1_drive_level_out == 16'h0000)
    else $error("output 1 not forced to zero");
  a_kill_two: assert property (  // R10
    kill2 |=> out2_drive_level_out == 16'h0000)
    else $error("output 2 not forced to zero");
  a_kill_both: assert property (  // R11
    ev.rise && event_function_select == kill_both_outputs
    |=> out1_drive_level_out == 16'h0000 && out2_drive_level_out == 16'h0000)
    else $error("outputs not both cleared");
  a_restore: assert property (  // R12
    !kill1 |=> out1_drive_level_out == $past(mv1_in))
    else $error("output 1 not restored");
  a_lock_hold: assert property (  // R13
    lock && wr_en |=> $stable(primary_setpoint) && $stable(event_function_select))
    else $error("parameter changed while locked");
  a_offset_sum: assert property (  // R15
    use_sp2 && second_setpoint_format
    |=> active_setpoint_out == sp_add($past(primary_setpoint), $past(secondary_setpoint)))
    else $error("offset set point not summed");
  a_mode_gate: assert property (  // R16
    !sp_allowed |=> active_setpoint_out == $past(primary_setpoint))
    else $error("set point swapped in wrong mode");
  a_tune_abort: assert property (  // R17
    abort |=> tune_abort_out && !tune_run_r ##1 tune_fail_out)
    else $error("tuning not aborted");
  a_edge_once: assert property (  // R18
    ev.rise |=> !ev.rise && ev.level)
    else $error("rise seen twice");

  c_sp_swap: cover property (ev.rise && use_sp2 ##1 ev.level);
  c_abort: cover property (tune_run_r && abort);
  c_alarm_retrig: cover property (ev.fall && alarm1_cond_in && clr_a1_fn(event_function_select));
  c_lock_write: cover property (lock && wr_en);

endmodule

// file: tb/event_contact.sv
`timescale 1ns/1ps
// switch, relay or timer contact that drives the event pin
module event_contact (
  input  wire logic core_clk_in,
  input  wire logic close_in,
  input  wire logic slow_in,
  output logic      pin_out = 1'b0
);
  // open contact at start; a switch has no reset pin, so one driver each
  logic [2:0] settle_r = 3'h0;

  // a slow contact settles late, so the pin lags the command by several cycles
  always @(posedge core_clk_in) begin
    if (close_in == pin_out) begin
      settle_r <= 3'h0;
    end else if (settle_r >= (slow_in ? 3'h5 : 3'h0)) begin
      pin_out <= close_in;
      settle_r <= 3'h0;
    end else begin
      settle_r <= settle_r + 3'h1;
    end
  end
endmodule

// file: tb/test_event_select.sv
`timescale 1ns/1ps
`include "event_select_defines.svh"
module test_event_select
  import event_select_pkg::*;
;
  logic        clk, rst, ev_cmd, ev_slow, ev_pin, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cond1, cond2, tdone, al1, al2, lock, trun, tabort, tfail, sp_ok;
  value_t      mv1, mv2, act_sp, drv1, drv2, exp_sp;
  gain_set_s   tgains, act_g;
  int          failures, check_count, cycles, aborts, abort_base;

  event_contact i_contact (.core_clk_in(clk), .close_in(ev_cmd), .slow_in(ev_slow),
    .pin_out(ev_pin));

  event_select i_dut (
    .core_clk_in(clk), .rst_in(rst), .event_pin_in(ev_pin), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .mv1_in(mv1), .mv2_in(mv2),
    .alarm1_cond_in(cond1), .alarm2_cond_in(cond2), .tune_done_in(tdone),
    .tune_gains_in(tgains), .active_setpoint_out(act_sp), .active_gains_out(act_g),
    .out1_drive_level_out(drv1), .out2_drive_level_out(drv2), .alarm1_out(al1),
    .alarm2_out(al2), .param_lock_out(lock), .tune_run_out(trun),
    .tune_abort_out(tabort), .tune_fail_out(tfail));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // the limit sits well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tabort === 1'b1) begin
      aborts <= aborts + 1;
    end
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check_out(input string what, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= `HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d, rd_q);
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h00000000, rd_q);
    check_count++;
    if (rd_q !== exp) begin
      failures++;
      $display("wrong value register %h expected %h seen %h", a, exp, rd_q);
    end
  endtask

  task automatic set_ctrl(input logic [3:0] f, input logic t, input logic [2:0] m);
    wr(`OFS_CTRL, {24'h000000, m, t, f});
  endtask

  // covers sync delay plus the slow contact settle time
  task automatic set_event(input logic v);
    ev_cmd <= v;
    repeat (12) @(posedge clk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, failures so far %0d", name, failures);
  endtask

  initial begin
    rst = 1'b1;
    {ev_cmd, ev_slow, hsel, hwrite, cond1, cond2, tdone} = 7'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = `HSIZE_WORD;
    mv1 = 16'h0000;
    mv2 = 16'h0000;
    tgains = 48'h000000000000;
    {failures, check_count, cycles, aborts} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_out("gains", 48'h00b4_0064_00fa, act_g);
    check_reg(`OFS_G2_TI, 32'h00000064);
    check_reg(`OFS_SP_PRI, 32'h00000000);
    check_out("hresp", 1'b0, hresp);
    end_test("reset");

    wr(`OFS_SP_PRI, 32'h00000064);
    wr(`OFS_SP_SEC, 32'h0000001e);
    wr(`OFS_G2_PB, 32'h00000011);
    wr(`OFS_G2_TI, 32'h00000022);
    wr(`OFS_G2_TD, 32'h00000033);
    // swap per code, format and mode
    for (int m = 0; m < 6; m++) begin
      for (int f = 0; f < 4; f++) begin
        for (int t = 0; t < 2; t++) begin
          set_ctrl(f[3:0], t[0], m[2:0]);
          set_event(1'b1);
          sp_ok = (f == 1 || f == 3) && (m == 1 || m == 2 || m == 5);
          exp_sp = !sp_ok ? 16'h0064 : (t == 1 ? 16'h0082 : 16'h001e);
          check_out("set point", exp_sp, act_sp);
          check_out("gains", (f >= 2) ? 48'h0011_0022_0033 : 48'h00b4_0064_00fa,
                    act_g);
          set_event(1'b0);
          check_out("set point", 16'h0064, act_sp);
          check_out("gains", 48'h00b4_0064_00fa, act_g);
        end
      end
    end
    check_reg(`OFS_ACT_SP, 32'h00000064);
    end_test("swap");

    // drive kill and restore, slow contact on the last code
    mv1 <= 16'h1234;
    mv2 <= 16'h0abc;
    for (int f = 7; f < 10; f++) begin
      ev_slow <= (f == 9);
      set_ctrl(f[3:0], 1'b0, 3'h5);
      set_event(1'b1);
      check_out("drive 1", (f != 8) ? 16'h0000 : 16'h1234, drv1);
      check_out("drive 2", (f != 7) ? 16'h0000 : 16'h0abc, drv2);
      set_event(1'b0);
      check_out("drive 1", 16'h1234, drv1);
      check_out("drive 2", 16'h0abc, drv2);
    end
    ev_slow <= 1'b0;
    end_test("outputs");

    // clear on activation, retrigger on release
    for (int f = 4; f < 7; f++) begin
      set_ctrl(4'h6, 1'b0, 3'h5);
      cond1 <= 1'b0;
      cond2 <= 1'b0;
      set_event(1'b1);
      set_event(1'b0);
      cond1 <= 1'b1;
      cond2 <= 1'b1;
      set_ctrl(f[3:0], 1'b0, 3'h5);
      check_out("alarm 1", 1'b1, al1);
      check_out("alarm 2", 1'b1, al2);
      set_event(1'b1);
      check_out("alarm 1", f == 5, al1);
      check_out("alarm 2", f == 4, al2);
      cond2 <= 1'b0;
      set_event(1'b0);
      check_out("alarm 1", 1'b1, al1);
      check_out("alarm 2", f == 4, al2);
    end
    end_test("alarms");

    set_ctrl(4'ha, 1'b0, 3'h5);
    set_event(1'b1);
    check_out("lock", 1'b1, lock);
    check_reg(`OFS_STATUS, 32'h00000019);
    wr(`OFS_SP_PRI, 32'h00000999);
    check_reg(`OFS_SP_PRI, 32'h00000064);
    set_event(1'b0);
    check_out("lock", 1'b0, lock);
    wr(`OFS_SP_PRI, 32'h00000070);
    check_reg(`OFS_SP_PRI, 32'h00000070);
    check_reg(8'h3c, 32'h00000000);
    end_test("lock");

    // tuned gains land in the second set
    set_ctrl(4'h2, 1'b0, 3'h5);
    set_event(1'b1);
    wr(`OFS_TUNE, 32'h00000001);
    repeat (3) @(posedge clk);
    check_out("tune run", 1'b1, trun);
    tgains <= 48'h0101_0202_0303;
    tdone <= 1'b1;
    @(posedge clk);
    tdone <= 1'b0;
    repeat (3) @(posedge clk);
    check_out("tune run", 1'b0, trun);
    check_reg(`OFS_G2_PB, 32'h00000101);
    check_reg(`OFS_G2_TD, 32'h00000303);
    check_reg(`OFS_G1_PB, 32'h000000b4);
    set_event(1'b0);
    end_test("tune store");

    // set point change by the event aborts tuning
    set_ctrl(4'h1, 1'b0, 3'h5);
    wr(`OFS_TUNE, 32'h00000001);
    repeat (3) @(posedge clk);
    abort_base = aborts;
    set_event(1'b1);
    check_out("abort pulses", 48'h000000000001, 48'(aborts - abort_base));
    check_out("tune fail", 1'b1, tfail);
    check_out("tune run", 1'b0, trun);
    wr(`OFS_TUNE, 32'h00000002);
    repeat (3) @(posedge clk);
    check_out("tune fail", 1'b0, tfail);
    set_event(1'b0);
    end_test("tune abort");
    stop_test();
  end
endmodule
